// ==== hw/odc_defs.svh ====
// constants of the octal dac two-wire command port
`ifndef ODC_DEFS_SVH
`define ODC_DEFS_SVH
// ==========================================
// target address
`define ODC_ADDR_UPPER    5'h03
// ==========================================
// command codes, upper nibble of the command byte
`define ODC_CMD_WR_IN     4'h1
`define ODC_CMD_UPD       4'h2
`define ODC_CMD_WR_UPD    4'h3
`define ODC_CMD_PD        4'h4
`define ODC_CMD_RB        4'h9
`define ODC_CMD_WR_ALL    4'ha
`define ODC_CMD_WR_UPD_ALL 4'hb
// ==========================================
// reset values
`define ODC_DAC_RST       16'h0000
`define ODC_PTR_RST       3'h0
// ==========================================
// serial framing
`define ODC_BITS_PER_BYTE 4'h8
`define ODC_LAST_TX_BIT   4'h7
`define ODC_FRAME_W       24
`define ODC_FIFO_DEPTH    16
`endif

// ==== hw/odc_pkg.sv ====
// types shared by the octal dac command port
package odc_pkg;
    // ==========================================
    // serial engine states, one-hot
    typedef enum logic [7:0] {
        ODC_IDLE     = 8'h01,
        ODC_ADDR     = 8'h02,
        ODC_ACK_ADDR = 8'h04,
        ODC_RX       = 8'h08,
        ODC_ACK_RX   = 8'h10,
        ODC_TX       = 8'h20,
        ODC_ACK_TX   = 8'h40,
        ODC_IGNORE   = 8'h80
    } odc_st_e;
    // ==========================================
    // one received write frame
    typedef struct packed {
        logic [3:0]  cmd;   // command nibble
        logic [3:0]  chan;  // channel address nibble
        logic [15:0] data;  // data word
    } odc_frame_s;
    // one channel power-down field
    typedef struct packed {
        logic powerdown_mode_hi;
        logic powerdown_mode_lo;
    } odc_pd_s;
    typedef logic [7:0][15:0] odc_bank_t;  // eight 16-bit channel words
endpackage

// ==== hw/odc_fifo.sv ====
// parameterised valid/ready fifo for received frames
`timescale 1ns/1ps
module odc_fifo #(
    parameter int W     = 24,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    // ==========================================
    // state
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;  // storage
        logic [AW-1:0]           wp;   // write pointer
        logic [AW-1:0]           rp;   // read pointer
        logic [AW:0]             cnt;  // words held
    } odc_fifo_s;
    odc_fifo_s q;
    odc_fifo_s d;
    logic      do_push;  // word taken in
    logic      do_pop;   // word handed out

    assign in_ready  = (q.cnt != FULL);
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign do_push   = in_valid & in_ready;
    assign do_pop    = out_valid & out_ready;
    // ==========================================
    // next state
    always_comb begin
        d = q;
        if (do_push) begin
            d.mem[q.wp] = in_data;
            d.wp = (q.wp == LAST) ? '0 : q.wp + 1'b1;
        end
        if (do_pop) begin
            d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
        end
        // count moves only when exactly one side acts
        if (do_push & ~do_pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (do_pop & ~do_push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end
    // ==========================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// ==== hw/odc_top.sv ====
// two-wire target port and double-buffered registers of an octal dac
`timescale 1ns/1ps
`include "odc_defs.svh"
module odc_top (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // two-wire bus
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe_n,
    // straps and strobes
    input  wire logic                addr_strap_hi,
    input  wire logic                addr_strap_lo,
    input  wire logic                load_strobe_n,
    input  wire logic                apply_hold,
    // channel outputs
    output odc_pkg::odc_bank_t       dac_value,
    output odc_pkg::odc_pd_s [7:0]   pd_mode,
    output logic [7:0]               out_gnd,
    output logic [7:0]               out_hiz
);
    import odc_pkg::*;
    // ==========================================
    // state
    typedef struct packed {
        odc_st_e         st;        // serial engine state
        logic            scl_r;     // sampled scl
        logic            scl_p;     // previous scl
        logic            sda_r;     // sampled sda
        logic            sda_p;     // previous sda
        logic            load_strobe_n_r;    // sampled strobe
        logic            load_strobe_n_p;    // previous strobe
        logic [7:0]      sh;        // shift register
        logic [3:0]      cnt;       // bit counter
        logic [1:0]      bidx;      // byte index in a write
        logic            rw;        // direction bit
        logic            half;      // low byte of pair in flight
        logic            mack;      // master acknowledged
        logic [2:0]      ptr;       // readback pointer
        odc_frame_s      frame;     // frame being assembled
        logic            sda_oe_n;  // pin release
        odc_bank_t       inp;       // input registers
        odc_bank_t       dac;       // dac registers
        odc_pd_s [7:0]   pd;        // power-down fields
        logic [7:0]      gnd;       // grounded outputs
        logic [7:0]      hiz;       // open outputs
    } odc_top_s;
    odc_top_s   q;
    odc_top_s   d;
    logic [6:0] my_addr;     // own target address
    logic       scl_rise;    // scl rising
    logic       scl_fall;    // scl falling
    logic       bus_start;   // start or repeated start
    logic       bus_stop;    // stop
    logic       load_strobe_n_fall;   // strobe falling edge
    logic       push;        // frame into fifo
    logic       push_ready;  // fifo has room
    odc_frame_s push_frame;  // frame being queued
    logic       pop;         // frame out of fifo
    logic       pop_valid;   // fifo holds a frame
    odc_frame_s pop_frame;   // frame at fifo head

    assign my_addr    = {`ODC_ADDR_UPPER, addr_strap_hi, addr_strap_lo};
    assign scl_rise   = q.scl_r & ~q.scl_p;
    assign scl_fall   = ~q.scl_r & q.scl_p;
    assign bus_start  = q.scl_r & q.scl_p & q.sda_p & ~q.sda_r;
    assign bus_stop   = q.scl_r & q.scl_p & ~q.sda_p & q.sda_r;
    assign load_strobe_n_fall  = q.load_strobe_n_p & ~q.load_strobe_n_r;
    assign push_frame = '{cmd: q.frame.cmd, chan: q.frame.chan,
                          data: {q.frame.data[15:8], q.sh}};
    assign pop        = pop_valid & ~apply_hold;
    assign push       = (q.st == ODC_RX) & scl_fall & (q.cnt == `ODC_BITS_PER_BYTE)
                        & (q.bidx == 2'h2) & push_ready;
    // ==========================================
    // frame buffer between serial side and registers
    odc_fifo #(
        .W     (`ODC_FRAME_W),
        .DEPTH (`ODC_FIFO_DEPTH)
    ) odc_fifo_inst (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (push_ready),
        .in_data   (push_frame),
        .out_valid (pop_valid),
        .out_ready (~apply_hold),
        .out_data  (pop_frame)
    );
    // ==========================================
    // next state: serial engine, then register updates
    always_comb begin
        d = q;
        // pin sampling
        d.scl_p  = q.scl_r;
        d.scl_r  = scl_i;
        d.sda_p  = q.sda_r;
        d.sda_r  = sda_i;
        d.load_strobe_n_p = q.load_strobe_n_r;
        d.load_strobe_n_r = load_strobe_n;
        if (bus_start) begin
            d.st       = ODC_ADDR;
            d.cnt      = '0;
            d.bidx     = '0;
            d.sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            d.st       = ODC_IDLE;
            d.sda_oe_n = 1'b1;
        end else begin
            unique case (q.st)
                ODC_IDLE, ODC_IGNORE: begin
                    d.sda_oe_n = 1'b1;  // stay off the bus
                end
                ODC_ADDR, ODC_RX: begin
                    if (scl_rise) begin  // sample while scl high
                        d.sh  = {q.sh[6:0], q.sda_r};
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == `ODC_BITS_PER_BYTE) begin
                        if (q.st == ODC_ADDR) begin
                            // ten-bit and general call codes never match
                            if (q.sh[7:1] == my_addr) begin
                                d.rw       = q.sh[0];
                                d.st       = ODC_ACK_ADDR;
                                d.sda_oe_n = 1'b0;
                            end else begin
                                d.st = ODC_IGNORE;
                            end
                        end else begin
                            if (q.bidx == 2'h0) begin  // command byte
                                d.frame.cmd  = q.sh[7:4];
                                d.frame.chan = q.sh[3:0];
                                if (q.sh[7:4] == `ODC_CMD_RB) begin
                                    // several channels selected: start at zero
                                    d.ptr = q.sh[3] ? `ODC_PTR_RST : q.sh[2:0];
                                end
                            end else if (q.bidx == 2'h1) begin  // high data byte
                                d.frame.data[15:8] = q.sh;
                            end
                            if (q.bidx != 2'h3) begin
                                d.bidx = q.bidx + 2'h1;
                            end
                            // last byte acked only when the fifo takes it
                            if ((q.bidx == 2'h2 && !push_ready) || q.bidx == 2'h3) begin
                                d.st = ODC_IGNORE;
                            end else begin
                                d.st       = ODC_ACK_RX;
                                d.sda_oe_n = 1'b0;
                            end
                        end
                    end
                end
                ODC_ACK_ADDR: begin
                    if (scl_fall) begin
                        d.cnt = '0;
                        if (q.rw) begin  // first readback byte, high half
                            d.sh       = q.inp[q.ptr][15:8];
                            d.half     = 1'b0;
                            d.st       = ODC_TX;
                            d.sda_oe_n = q.inp[q.ptr][15];
                        end else begin
                            d.st       = ODC_RX;
                            d.sda_oe_n = 1'b1;
                        end
                    end
                end
                ODC_ACK_RX: begin
                    if (scl_fall) begin
                        d.st       = ODC_RX;
                        d.cnt      = '0;
                        d.sda_oe_n = 1'b1;
                    end
                end
                ODC_TX: begin
                    if (scl_fall) begin  // change data only after scl falls
                        if (q.cnt == `ODC_LAST_TX_BIT) begin
                            d.st       = ODC_ACK_TX;
                            d.sda_oe_n = 1'b1;
                        end else begin
                            d.sh       = {q.sh[6:0], 1'b0};
                            d.cnt      = q.cnt + 4'h1;
                            d.sda_oe_n = q.sh[6];
                        end
                    end
                end
                ODC_ACK_TX: begin
                    if (scl_rise) begin
                        d.mack = ~q.sda_r;
                    end else if (scl_fall) begin
                        if (!q.mack) begin  // nack ends the read
                            d.st = ODC_IGNORE;
                        end else if (!q.half) begin  // low byte of the pair
                            d.sh       = q.inp[q.ptr][7:0];
                            d.half     = 1'b1;
                            d.st       = ODC_TX;
                            d.cnt      = '0;
                            d.sda_oe_n = q.inp[q.ptr][7];
                        end else begin  // next channel, wraps 7 to 0
                            d.ptr      = q.ptr + 3'h1;
                            d.sh       = q.inp[d.ptr][15:8];
                            d.half     = 1'b0;
                            d.st       = ODC_TX;
                            d.cnt      = '0;
                            d.sda_oe_n = q.inp[d.ptr][15];
                        end
                    end
                end
            endcase
        end
        // falling strobe copies every input register
        if (load_strobe_n_fall) begin
            d.dac = q.inp;
        end
        // queued frame applied to the channel registers
        if (pop) begin
            unique case (pop_frame.cmd)
                `ODC_CMD_WR_IN: begin
                    if (!pop_frame.chan[3]) begin
                        d.inp[pop_frame.chan[2:0]] = pop_frame.data;
                        if (!q.load_strobe_n_r) begin
                            d.dac[pop_frame.chan[2:0]] = pop_frame.data;
                        end
                    end
                end
                `ODC_CMD_UPD: begin
                    for (int i = 0; i < 8; i++) begin  // low data bits pick channels
                        if (pop_frame.data[i]) begin
                            d.dac[i] = q.inp[i];
                        end
                    end
                end
                `ODC_CMD_WR_UPD: begin
                    if (!pop_frame.chan[3]) begin
                        d.inp[pop_frame.chan[2:0]] = pop_frame.data;
                        d.dac[pop_frame.chan[2:0]] = pop_frame.data;
                    end
                end
                `ODC_CMD_PD: begin  // channel nibble ignored, dac kept
                    d.pd = pop_frame.data;
                end
                `ODC_CMD_WR_ALL: begin
                    d.inp = {8{pop_frame.data}};
                end
                `ODC_CMD_WR_UPD_ALL: begin
                    d.inp = {8{pop_frame.data}};
                    d.dac = {8{pop_frame.data}};
                end
                default: begin
                    // reserved and unsupported codes leave every register alone
                end
            endcase
        end
        // output stage decode per channel
        for (int i = 0; i < 8; i++) begin
            d.gnd[i] = d.pd[i].powerdown_mode_lo & ~d.pd[i].powerdown_mode_hi;
            d.hiz[i] = d.pd[i].powerdown_mode_hi;
        end
    end
    // ==========================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q          <= '0;
            q.st       <= ODC_IDLE;
            q.scl_r    <= 1'b1;
            q.scl_p    <= 1'b1;
            q.sda_r    <= 1'b1;
            q.sda_p    <= 1'b1;
            q.load_strobe_n_r   <= 1'b1;
            q.load_strobe_n_p   <= 1'b1;
            q.sda_oe_n <= 1'b1;
            q.inp      <= {8{`ODC_DAC_RST}};
            q.dac      <= {8{`ODC_DAC_RST}};
        end else begin
            q <= d;
        end
    end
    // outputs straight from the state register, except sda_o, which is tied low
    assign sda_o     = 1'b0;
    assign sda_oe_n  = q.sda_oe_n;
    assign dac_value = q.dac;
    assign pd_mode   = q.pd;
    assign out_gnd   = q.gnd;
    assign out_hiz   = q.hiz;
    // ==========================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_ack_own;
        (q.st == ODC_ADDR) && !bus_start && !bus_stop && scl_fall && (q.cnt == 4'h8)
            && (q.sh[7:1] == my_addr) |=> (q.st == ODC_ACK_ADDR) && !sda_oe_n;
    endproperty
    a_ack_own: assert property (p_ack_own) else $error("own address not acked");
    property p_ignore_other;
        (q.st == ODC_ADDR) && !bus_start && !bus_stop && scl_fall && (q.cnt == 4'h8)
            && (q.sh[7:1] != my_addr) |=> (q.st == ODC_IGNORE) [*2] ##0 sda_oe_n;
    endproperty
    a_ignore_other: assert property (p_ignore_other) else $error("foreign addr taken");
    property p_nine;
        (q.st != ODC_ACK_RX) ##1 (q.st == ODC_ACK_RX) |-> $past(q.cnt) == 4'h8;
    endproperty
    a_nine: assert property (p_nine) else $error("ack not after eight bits");
    property p_sda_low_scl;
        $changed(sda_oe_n) |-> !$past(q.scl_r) || (q.st == ODC_IDLE) || (q.st == ODC_ADDR);
    endproperty
    a_sda_low_scl: assert property (p_sda_low_scl) else $error("sda moved with scl high");
    property p_rb_zero;
        (q.st == ODC_RX) && !bus_start && !bus_stop && scl_fall && (q.cnt == 4'h8)
            && (q.bidx == 2'h0) && (q.sh[7:4] == 4'h9) && q.sh[3] |=> q.ptr == 3'h0;
    endproperty
    a_rb_zero: assert property (p_rb_zero) else $error("multi select not at zero");
    property p_ptr_step;
        (q.st == ODC_ACK_TX) && !bus_start && !bus_stop && scl_fall && q.mack && q.half
            |=> (q.ptr == 3'($past(q.ptr) + 3'h1)) && (q.st == ODC_TX) ##1 !q.half;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");
    property p_pd_keep;
        pop && (pop_frame.cmd == 4'h4) && !load_strobe_n_fall
            |=> (q.pd == $past(pop_frame.data)) && (q.dac == $past(q.dac));
    endproperty
    a_pd_keep: assert property (p_pd_keep) else $error("power-down frame misapplied");
    property p_wr_low;
        pop && (pop_frame.cmd == 4'h1) && !pop_frame.chan[3] && !q.load_strobe_n_r
            |=> q.dac[$past(pop_frame.chan[2:0])] == $past(pop_frame.data);
    endproperty
    a_wr_low: assert property (p_wr_low) else $error("transparent write missed dac");
    property p_load_strobe_n_copy;
        load_strobe_n_fall && !pop |=> q.dac == $past(q.inp);
    endproperty
    a_load_strobe_n_copy: assert property (p_load_strobe_n_copy) else $error("strobe edge did not copy");
endmodule

// ==== sim/odc_master.sv ====
// two-wire bus controller model facing the command port
`timescale 1ns/1ps
module odc_master (
    // clock
    input  wire logic clk,
    // bus: scl driven, sda only pulled low or released
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // ==========================================
    // bus phases
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end
    // one bus phase lasts eight clk cycles
    task automatic half();
        repeat (8) @(posedge clk);
    endtask
    // start or repeated start: sda falls while scl high
    task automatic start();
        sda_pull <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_pull <= 1'b1;
        half();
        scl <= 1'b0;
        half();
    endtask
    // eight bits then acknowledge, sda moved only while scl low
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_pull <= !tx[i];
            half();
            scl <= 1'b1;
            half();
            rx[i] = sda;
            scl <= 1'b0;
            half();
        end
    endtask
    // stop: sda rises while scl high
    task automatic stop();
        sda_pull <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_pull <= 1'b0;
        half();
    endtask
endmodule

// ==== sim/odc_top_test.sv ====
// self-checking bench of the octal dac two-wire command port
`timescale 1ns/1ps
`include "odc_defs.svh"
module odc_top_test;
    import odc_pkg::*;
    // ==========================================
    // signals
    logic          clk, rst, scl, sda_pull, sda_o, sda_oe_n;
    logic          st_hi, st_lo, ldn, hold;
    odc_bank_t     dac_value;
    odc_pd_s [7:0] pd_mode;
    logic [7:0]    out_gnd, out_hiz;
    logic [8:0]    rx;
    logic [3:0]    ak;
    logic [15:0]   inreg [8];  // expected input registers
    int            n_mismatch = 0;
    int            n_tests = 0;
    wire           sda = !(sda_pull || (!sda_oe_n && !sda_o));  // pulled-up wire

    odc_top odc_top_inst (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_strap_hi(st_hi),
        .addr_strap_lo(st_lo), .load_strobe_n(ldn), .apply_hold(hold),
        .dac_value(dac_value), .pd_mode(pd_mode), .out_gnd(out_gnd), .out_hiz(out_hiz));
    odc_master odc_master_inst (.clk(clk), .scl(scl), .sda_pull(sda_pull), .sda(sda));

    // ==========================================
    // helpers
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one write frame; ak holds the four acknowledge bits
    task automatic wr(input logic [6:0] a, input logic [3:0] c, ch, input logic [15:0] d);
        logic [31:0] f;
        f = {a, 1'b0, c, ch, d};
        odc_master_inst.start();
        for (int k = 0; k < 4; k++) begin
            odc_master_inst.xfer({f[31-8*k -: 8], 1'b1}, rx);
            ak[3-k] = rx[0];
        end
        odc_master_inst.stop();
        repeat (4) @(posedge clk);
    endtask
    // readback of n pairs from channel ch
    task automatic rd(input logic [3:0] ch, input int n);
        logic [7:0] hi;
        odc_master_inst.start();
        odc_master_inst.xfer({`ODC_ADDR_UPPER, st_hi, st_lo, 1'b0, 1'b1}, rx);
        odc_master_inst.xfer({`ODC_CMD_RB, ch, 1'b1}, rx);
        check("setup ack", 16'(rx[0]), 16'h0000);
        odc_master_inst.start();
        odc_master_inst.xfer({`ODC_ADDR_UPPER, st_hi, st_lo, 1'b1, 1'b1}, rx);
        check("read ack", 16'(rx[0]), 16'h0000);
        for (int k = 0; k < n; k++) begin
            odc_master_inst.xfer(9'h1fe, rx);
            hi = rx[8:1];
            odc_master_inst.xfer({8'hff, k == n - 1}, rx);
            check("read", {hi, rx[8:1]}, inreg[(ch + k) % 8]);
        end
        odc_master_inst.stop();
    endtask

    // ==========================================
    // watchdog
    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
    // ==========================================
    // tests
    initial begin
        rst <= 1'b1;
        {st_hi, st_lo, ldn, hold} <= 4'b0010;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        // every strap address, strobe high: input only
        for (int k = 0; k < 8; k++) begin
            {st_hi, st_lo} <= 2'(k);
            inreg[k] = 16'ha5c0 + 16'(k);
            wr({`ODC_ADDR_UPPER, 2'(k)}, `ODC_CMD_WR_IN, 4'(k), inreg[k]);
            check("write ack", 16'(ak), 16'h0000);
            check("dac held", dac_value[k], 16'h0000);
        end
        wr({`ODC_ADDR_UPPER, 2'b01}, `ODC_CMD_WR_UPD, 4'h0, 16'hdead);
        check("foreign ack", 16'(ak), 16'h000f);
        wr(7'h00, `ODC_CMD_WR_UPD, 4'h0, 16'hdead);
        check("general call", 16'(ak), 16'h000f);
        // falling strobe copies every input register
        ldn <= 1'b0;
        repeat (6) @(posedge clk);
        for (int k = 0; k < 8; k++)
            check("strobe copy", dac_value[k], inreg[k]);
        inreg[2] = 16'h1234;
        wr({`ODC_ADDR_UPPER, 2'b11}, `ODC_CMD_WR_IN, 4'h2, inreg[2]);
        check("transparent", dac_value[2], 16'h1234);
        ldn <= 1'b1;
        inreg[3] = 16'h3333;
        wr({`ODC_ADDR_UPPER, 2'b11}, `ODC_CMD_WR_IN, 4'h3, inreg[3]);
        check("input only", dac_value[3], 16'ha5c3);
        wr({`ODC_ADDR_UPPER, 2'b11}, `ODC_CMD_UPD, 4'h0, 16'h0008);
        check("update", dac_value[3], 16'h3333);
        wr({`ODC_ADDR_UPPER, 2'b11}, 4'h8, 4'h1, 16'hffff);
        check("reserved", dac_value[1], 16'ha5c1);
        // power-down fields, channel nibble ignored
        wr({`ODC_ADDR_UPPER, 2'b11}, `ODC_CMD_PD, 4'h6, 16'hc1e4);
        check("pd mode", 16'(pd_mode), 16'hc1e4);
        check("grounded", 16'(out_gnd), 16'h0012);
        check("open", 16'(out_hiz), 16'h008c);
        check("pd keeps", dac_value[7], 16'ha5c7);
        inreg[5] = 16'h0f0f;
        wr({`ODC_ADDR_UPPER, 2'b11}, `ODC_CMD_WR_UPD, 4'h5, inreg[5]);
        check("pd write", dac_value[5], 16'h0f0f);
        rd(4'h6, 3);
        rd(4'h8, 2);
        // fifo fills under hold, seventeenth frame refused
        hold <= 1'b1;
        for (int i = 0; i < 17; i++) begin
            wr({`ODC_ADDR_UPPER, 2'b11}, `ODC_CMD_WR_UPD, 4'(i % 8), 16'h0100 + 16'(i));
            check("fifo ack", 16'(ak), (i < 16) ? 16'h0000 : 16'h0001);
        end
        check("stalled", dac_value[0], 16'ha5c0);
        hold <= 1'b0;
        repeat (40) @(posedge clk);
        check("drained", dac_value[0], 16'h0108);
        check("drained", dac_value[7], 16'h010f);
        // broadcast writes: input bank only, then input and dac banks
        wr({`ODC_ADDR_UPPER, 2'b11}, `ODC_CMD_WR_ALL, 4'h0, 16'h5a5a);
        check("all input", dac_value[4], 16'h010c);
        ldn <= 1'b0;
        repeat (6) @(posedge clk);
        check("all copied", dac_value[4], 16'h5a5a);
        wr({`ODC_ADDR_UPPER, 2'b11}, `ODC_CMD_WR_UPD_ALL, 4'h0, 16'h7e7e);
        check("all dac", dac_value[6], 16'h7e7e);
        check("sda data", 16'(sda_o), 16'h0000);
        stop_test();
    end
endmodule
